// file: hw/acsw_counter.v
// Asynchronous-capable 16-bit counter with sleep wake, on AHB-Lite
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "acsw_defines.vh"
// ===========================================
// Register map, one byte per word, byte address is four times the index
//   0x0b interrupt_control: bit 7 global enable, bit 6 peripheral enable
//   0x0c peripheral_irq_flags: bit 0 overflow flag, set by hardware
//   0x0e count_low_byte, 0x0f count_high_byte: no reset, kept over resets
//   0x10 counter_control: run, clock select, bypass, oscillator, prescale, gate
//   0x8c peripheral_irq_enables: bit 0 overflow interrupt enable
//   0x40 system configuration: bit 0 system clock is the internal oscillator
//   0x41 port view: pin levels in bits 1:0, directions in bits 5:4
// Reads take one wait state, writes none; the response is always OKAY.
// Limitation: a count write that meets an increment keeps the written byte
// and drops the increment, so software should stop the counter first.
module acsw_counter (
   input wire clk,
   input wire reset_n,
   input wire por_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire ext_clk_pin,
   input wire osc_in_pin,
   output reg osc_out_pin,
   input wire gate_n_pin,
   input wire sleep_active,
   input wire port_pin4,
   input wire port_pin5,
   output reg pin4_direction,
   output reg pin5_direction,
   output reg wake_q,
   output reg irq_vector_q,
   output reg osc_fault_q
);
   // ===========================================
   // Register state
   reg [7:0] ctrl_q;
   reg [7:0] intctl_q;
   reg [7:0] enables_q;
   reg flag_q;
   reg [15:0] count_q;
   reg [2:0] presc_q;
   reg sysclk_internal_q;
   reg dir4_q;
   reg dir5_q;
   reg [7:0] addr_q;
   reg wr_q;
   reg rd_q;
   reg prev_clk_q;
   wire ext_sync;
   wire osc_sync;
   wire pin4_sync;
   wire pin5_sync;
   wire gate_n_sync;
   wire [4:0] pin_raw;
   wire [4:0] pin_sync;
   genvar gi;
   // ===========================================
   // Pin synchronisers: every pin lane gets the same three-stage filter
   assign pin_raw = {gate_n_pin, port_pin5, port_pin4, osc_in_pin, ext_clk_pin};
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
         acsw_sync3 u_sync (
            .clk(clk),
            .reset_n(reset_n),
            .din(pin_raw[gi]),
            .dout_q(pin_sync[gi])
         );
      end
   endgenerate
   // Lane order must match the concatenation above
   assign ext_sync = pin_sync[0];
   assign osc_sync = pin_sync[1];
   assign pin4_sync = pin_sync[2];
   assign pin5_sync = pin_sync[3];
   assign gate_n_sync = pin_sync[4];
   // ===========================================
   // Clock source and mode decode
   wire osc_ok = ctrl_q[`ACSW_CTRL_OSCEN] & sysclk_internal_q;
   wire src_lvl = osc_ok ? osc_sync : ext_sync;
   wire async_mode = ctrl_q[`ACSW_CTRL_EXTCLK] & ctrl_q[`ACSW_CTRL_SYNCN];
   wire gate_ok = ~ctrl_q[`ACSW_CTRL_GATE] | ~gate_n_sync;
   wire run = ctrl_q[`ACSW_CTRL_RUN] & gate_ok;
   wire src_rise = src_lvl & ~prev_clk_q;
   // Internal mode ticks every core cycle; sleep halts all but async
   wire tick_raw = ctrl_q[`ACSW_CTRL_EXTCLK] ? src_rise : 1'b1;
   wire may_run = run & (~sleep_active | async_mode);
   wire [1:0] ps = ctrl_q[`ACSW_CTRL_PS_HI:`ACSW_CTRL_PS_LO];
   reg [2:0] ps_mask;
   // Prescale mask: one, two, four or eight source edges per increment
   always @* begin
      case (ps)
         2'd0: ps_mask = 3'd0;
         2'd1: ps_mask = 3'd1;
         2'd2: ps_mask = 3'd3;
         default: ps_mask = 3'd7;
      endcase
   end
   wire ps_hit = (presc_q & ps_mask) == ps_mask;
   wire tick = may_run & tick_raw;
   wire inc = tick & ps_hit;
   wire ovf = inc & (count_q == 16'hffff);
   // ===========================================
   // Bus address phase decode
   wire take = hsel & hready & htrans[1];
   wire wr_lo = wr_q & (addr_q == `ACSW_IDX_CNTLO);
   wire wr_hi = wr_q & (addr_q == `ACSW_IDX_CNTHI);
   wire wr_flags = wr_q & (addr_q == `ACSW_IDX_FLAGS);
   // ===========================================
   // Read mux: count read straight from count_q, so the two byte reads can tear
   reg [7:0] rd_d;
   always @* begin
      rd_d = 8'h00;
      if (addr_q == `ACSW_IDX_INTCTL) begin
         rd_d = intctl_q;
      end else if (addr_q == `ACSW_IDX_FLAGS) begin
         rd_d = {7'h00, flag_q};
      end else if (addr_q == `ACSW_IDX_CNTLO) begin
         rd_d = count_q[7:0];
      end else if (addr_q == `ACSW_IDX_CNTHI) begin
         rd_d = count_q[15:8];
      end else if (addr_q == `ACSW_IDX_CTRL) begin
         rd_d = ctrl_q & `ACSW_CTRL_MASK;
      end else if (addr_q == `ACSW_IDX_ENABLES) begin
         rd_d = enables_q;
      end else if (addr_q == `ACSW_IDX_SYSCFG) begin
         rd_d = {7'h00, sysclk_internal_q};
      end else if (addr_q == `ACSW_IDX_PORT) begin
         // Pins held by the oscillator read low, directions high
         rd_d = {2'b00, dir5_q | osc_ok, dir4_q | osc_ok, 2'b00,
                 pin5_sync & ~osc_ok, pin4_sync & ~osc_ok};
      end
   end
   // ===========================================
   // AHB-Lite slave: writes without wait, reads with one, always OKAY
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_q <= take & hwrite;
         rd_q <= take & ~hwrite;
         if (take) begin
            addr_q <= haddr[9:2]; // Word index; byte lanes are not decoded
         end
         // The mux decodes the latched index, so read data is registered one
         // edge later; the wait state also lets a just-written value be seen
         hreadyout <= ~(take & ~hwrite);
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         if (rd_q) begin
            hrdata <= {24'h00_0000, rd_d};
         end
      end
   end
   // ===========================================
   // Control and configuration registers; POR and brown-out only
   wire wr_ctrl = wr_q & (addr_q == `ACSW_IDX_CTRL);
   wire wr_intctl = wr_q & (addr_q == `ACSW_IDX_INTCTL);
   wire wr_enables = wr_q & (addr_q == `ACSW_IDX_ENABLES);
   wire wr_syscfg = wr_q & (addr_q == `ACSW_IDX_SYSCFG);
   wire wr_port = wr_q & (addr_q == `ACSW_IDX_PORT);
   // Counter control; a device reset leaves the mode untouched
   always @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         ctrl_q <= `ACSW_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= hwdata[7:0] & `ACSW_CTRL_MASK;
      end
   end
   // Interrupt control: bit 7 global enable, bit 6 peripheral enable
   always @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         intctl_q <= 8'h00;
      end else if (wr_intctl) begin
         intctl_q <= hwdata[7:0];
      end
   end
   // Interrupt enables: bit 0 arms the overflow request
   always @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         enables_q <= 8'h00;
      end else if (wr_enables) begin
         enables_q <= hwdata[7:0];
      end
   end
   // System clock source; the shared oscillator needs the internal one
   always @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         sysclk_internal_q <= 1'b1;
      end else if (wr_syscfg) begin
         sysclk_internal_q <= hwdata[0];
      end
   end
   // Port directions; overridden while the oscillator holds the pins
   always @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         dir4_q <= 1'b1;
         dir5_q <= 1'b1;
      end else if (wr_port) begin
         dir4_q <= hwdata[4];
         dir5_q <= hwdata[5];
      end
   end
   // ===========================================
   // Count register; no reset, so it survives every reset
   // A byte write beats a same-cycle increment: the increment is lost,
   // which is why software is asked to stop the counter before writing
   always @(posedge clk) begin
      if (wr_lo) begin
         count_q[7:0] <= hwdata[7:0];
      end else if (wr_hi) begin
         count_q[15:8] <= hwdata[7:0];
      end else if (inc) begin
         count_q <= count_q + 16'h0001; // wraps to zero
      end
   end
   // ===========================================
   // Source edge detector; resets low to match the idle pin level, so no
   // false edge follows reset
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_clk_q <= 1'b0;
      end else begin
         prev_clk_q <= src_lvl;
      end
   end
   // Prescaler: any count byte write starts the division afresh
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         presc_q <= 3'd0;
      end else if (wr_lo | wr_hi) begin
         presc_q <= 3'd0;
      end else if (tick) begin
         presc_q <= ps_hit ? 3'd0 : presc_q + 3'd1;
      end
   end
   // Overflow flag: set beats a same-cycle clear; enables not involved
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_q <= 1'b0;
      end else if (ovf) begin
         flag_q <= 1'b1;
      end else if (wr_flags) begin
         flag_q <= hwdata[`ACSW_FLAG_OVF];
      end
   end
   // ===========================================
   // Wake and vector requests; plain levels that follow the flag, so they
   // drop once software clears it in its service routine, or clears a bit that gates them
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_q <= 1'b0;
         irq_vector_q <= 1'b0;
      end else begin
         // Wake needs run, overflow enable and peripheral enable
         wake_q <= flag_q & ctrl_q[`ACSW_CTRL_RUN] & enables_q[0]
                   & intctl_q[`ACSW_INT_PERIPH];
         // Vector only with global enable; else resume after sleep
         irq_vector_q <= flag_q & enables_q[0] & intctl_q[`ACSW_INT_PERIPH]
                         & intctl_q[`ACSW_INT_GLOBAL];
      end
   end
   // ===========================================
   // Oscillator drive, port directions and the configuration fault
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_out_pin <= 1'b0;
         pin4_direction <= 1'b1;
         pin5_direction <= 1'b1;
         osc_fault_q <= 1'b0;
      end else begin
         // Inverting amplifier drive keeps running in sleep
         osc_out_pin <= osc_ok & ~osc_sync;
         pin4_direction <= dir4_q | osc_ok;
         pin5_direction <= dir5_q | osc_ok;
         osc_fault_q <= ctrl_q[`ACSW_CTRL_OSCEN] & ~sysclk_internal_q;
      end
   end
endmodule // acsw_counter

// file: hw/acsw_defines.vh
// Offsets, field positions, reset values and timing counts of the counter block
`ifndef ACSW_DEFINES_VH
`define ACSW_DEFINES_VH
// Register indices; the byte address on the bus is four times the index
`define ACSW_IDX_INTCTL 8'h0b
`define ACSW_IDX_FLAGS 8'h0c
`define ACSW_IDX_CNTLO 8'h0e
`define ACSW_IDX_CNTHI 8'h0f
`define ACSW_IDX_CTRL 8'h10
`define ACSW_IDX_ENABLES 8'h8c
`define ACSW_IDX_SYSCFG 8'h40
`define ACSW_IDX_PORT 8'h41
// Counter control fields
`define ACSW_CTRL_RUN 0
`define ACSW_CTRL_EXTCLK 1
`define ACSW_CTRL_SYNCN 2
`define ACSW_CTRL_OSCEN 3
`define ACSW_CTRL_PS_LO 4
`define ACSW_CTRL_PS_HI 5
`define ACSW_CTRL_GATE 6
`define ACSW_CTRL_RESET 8'h00
`define ACSW_CTRL_MASK 8'h7f
// Interrupt control and flag fields
`define ACSW_INT_GLOBAL 7
`define ACSW_INT_PERIPH 6
`define ACSW_FLAG_OVF 0
// Timing: 100 MHz core clock
`define ACSW_CLK_MHZ 100
`define ACSW_OSC_MAX_KHZ 37
`endif

// file: hw/acsw_sync3.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module acsw_sync3 (
   input wire clk,
   input wire reset_n,
   input wire din,
   output reg dout_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   // ===========================================
   // Shift chain; stage one feeds only stage two
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         dout_q <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            dout_q <= s3_q; // Level changes once two stages agree
         end
      end
   end
endmodule // acsw_sync3

// file: tb/acsw_counter_sva.sv
// Port-level assertions for the counter block
`timescale 1ns/1ps
module acsw_counter_chk (
   input wire clk,
   input wire reset_n,
   input wire por_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire pin4_direction,
   input wire pin5_direction,
   input wire wake_q,
   input wire irq_vector_q,
   input wire osc_fault_q
);
   reg ph_q;
   reg wr_q;
   reg [7:0] a_q;
   reg [7:0] ctl_q;
   reg [7:0] ien_q;
   reg [7:0] int_q;
   reg [7:0] sys_q;
   wire osc_ok = ctl_q[3] && sys_q[0];
   wire wk = ctl_q[0] && ien_q[0] && int_q[6];
   wire rd_hit = ph_q && !wr_q && hready;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n || !por_n);
   // =====
   // Bus tracking: a data phase lasts until hready is seen high
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ph_q <= 1'h0;
         wr_q <= 1'h0;
         a_q <= 8'h00;
      end else begin
         if (hsel && hready && htrans[1]) begin
            ph_q <= 1'h1;
            wr_q <= hwrite;
            a_q <= haddr[9:2];
         end else if (hready) begin
            ph_q <= 1'h0;
         end
      end
   end
   // Shadow registers; only power-on resets them, a device reset keeps them
   always @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         ctl_q <= 8'h00;
         ien_q <= 8'h00;
         int_q <= 8'h00;
         sys_q <= 8'h01;
      end else if (ph_q && wr_q && hready) begin
         case (a_q)
            8'h10: ctl_q <= hwdata[7:0];
            8'h8c: ien_q <= hwdata[7:0];
            8'h0b: int_q <= hwdata[7:0];
            8'h40: sys_q <= hwdata[7:0];
            default: ;
         endcase
      end
   end
   // =====
   // Properties
   property p_dir; osc_ok [*3] |-> pin4_direction && pin5_direction; endproperty
   a_dir: assert property (p_dir) else $error("pin direction not forced");
   property p_flt; $rose(ctl_q[3] && !sys_q[0]) |-> ##[1:3] osc_fault_q; endproperty
   a_flt: assert property (p_flt) else $error("oscillator fault missing");
   property p_nflt; !ctl_q[3] [*3] |-> !osc_fault_q; endproperty
   a_nflt: assert property (p_nflt) else $error("stray oscillator fault");
   property p_wake; !wk [*3] |-> !wake_q; endproperty
   a_wake: assert property (p_wake) else $error("wake while not armed");
   property p_vec; !(ien_q[0] && int_q[6] && int_q[7]) [*3] |-> !irq_vector_q; endproperty
   a_vec: assert property (p_vec) else $error("vector while not armed");
   property p_inl; !int_q[7] [*3] |-> !irq_vector_q; endproperty
   a_inl: assert property (p_inl) else $error("vector without global enable");
   property p_ctl; rd_hit && a_q == 8'h10 |-> hrdata[7:0] == {1'h0, ctl_q[6:0]}; endproperty
   a_ctl: assert property (p_ctl) else $error("control read wrong");
   property p_ien; rd_hit && a_q == 8'h8c |-> hrdata[0] == ien_q[0]; endproperty
   a_ien: assert property (p_ien) else $error("enable read wrong");
   c_wake: cover property (wake_q);
   c_vec: cover property (irq_vector_q);
   c_flt: cover property (osc_fault_q);
endmodule // acsw_counter_chk
bind acsw_counter acsw_counter_chk i_chk (
   .clk(clk),
   .reset_n(reset_n),
   .por_n(por_n),
   .hsel(hsel),
   .haddr(haddr),
   .htrans(htrans),
   .hwrite(hwrite),
   .hwdata(hwdata),
   .hready(hready),
   .hrdata(hrdata),
   .pin4_direction(pin4_direction),
   .pin5_direction(pin5_direction),
   .wake_q(wake_q),
   .irq_vector_q(irq_vector_q),
   .osc_fault_q(osc_fault_q)
);

// file: tb/acsw_clk_src.sv
// Behavioural external count clock source
`timescale 1ns/1ps
module acsw_clk_src (
   output logic pin
);
   // =====
   // Bursts of 125 ns periods; rests low between them so no stray edge counts
   initial pin = 1'h0;
   task automatic pulse(input int n);
      repeat (n) begin
         #62.5 pin = 1'h1;
         #62.5 pin = 1'h0;
      end
      #500;
   endtask
endmodule // acsw_clk_src

// file: tb/tb_acsw_counter.sv
// Self-checking bench for the counter block
`timescale 1ns/1ps
module tb_acsw_counter;
   logic clk, reset_n, por_n, hsel, hwrite, sleep_active, gate_n_pin, port_pin4, port_pin5;
   logic [31:0] haddr, hwdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] s;
   logic [16:0] e;
   logic [7:0] ra [5] = '{8'h0b, 8'h0c, 8'h10, 8'h8c, 8'h20};
   wire [31:0] hrdata;
   wire hreadyout, hresp, osc_out_pin, pin4_direction, pin5_direction;
   wire wake_q, irq_vector_q, osc_fault_q, ext_clk_pin, osc_in_pin;
   wire hready = hreadyout;
   int errors, checked, t;
   acsw_counter i_dut (.*);
   acsw_clk_src i_src (.pin(ext_clk_pin));
   assign osc_in_pin = ext_clk_pin;
   // =====
   // Clock, time-zero values and a watchdog against hangs
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial begin
      {reset_n, por_n, hsel, hwrite, sleep_active, gate_n_pin} = '0;
      {port_pin4, port_pin5} = 2'h3;
      {haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      #200_000;
      errors++;
      report_and_stop;
   end
   // =====
   // Tasks: compare, single AHB-Lite word transfer, count byte pair
   task automatic chk(input string n, input logic [31:0] v, x);
      checked++;
      if (v !== x) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, x, v);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h00_0000, a, 2'b00};
      do @(posedge clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask
   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m, x);
      bus(1'h0, a, 32'h0000_0000);
      chk(n, q & m, x);
      chk("response", 32'({hreadyout, hresp}), 32'h0000_0002);
   endtask
   // Bytes are read apart; callers stop the counter or expect no carry between reads
   task automatic chkcnt(input logic [15:0] x);
      rc("count low", 8'h0e, 32'hffff_ffff, {24'h00_0000, x[7:0]});
      rc("count high", 8'h0f, 32'hffff_ffff, {24'h00_0000, x[15:8]});
   endtask
   task automatic wcnt(input logic [15:0] x);
      wr(8'h0e, {24'h00_0000, x[7:0]});
      wr(8'h0f, {24'h00_0000, x[15:8]});
   endtask
   function automatic logic [16:0] nxt(input logic [15:0] v, input int p, input int n);
      return {1'h0, v} + 17'(n >> p);
   endfunction
   task automatic done;
      $display("test %0d done", t);
      t++;
   endtask
   task automatic report_and_stop;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // =====
   // Main sequence
   initial begin
      s = 16'($urandom(32'h9be4));
      repeat (4) @(posedge clk);
      reset_n <= 1'h1;
      por_n <= 1'h1;
      wr(8'h20, 32'hffff_ffff);
      foreach (ra[i]) rc("reset value", ra[i], 32'hffff_ffff, 32'h0000_0000);
      done;
      wr(8'h10, 32'h0000_00ff);
      rc("control", 8'h10, 32'hffff_ffff, 32'h0000_007f);
      rc("port", 8'h41, 32'h0000_0033, 32'h0000_0030);
      wr(8'h40, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk("fault", 32'(osc_fault_q), 32'h0000_0001);
      wr(8'h40, 32'h0000_0001);
      done;
      wr(8'h10, 32'h0000_0030);
      wcnt(s);
      reset_n <= 1'h0;
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      rc("control", 8'h10, 32'hffff_ffff, 32'h0000_0030);
      chkcnt(s);
      done;
      // Odd burst length leaves prescaler residue that a count write must clear
      for (int p = 0; p < 4; p++) begin
         s = (p == 0) ? 16'hfffc : 16'($urandom);
         wr(8'h10, 32'h0000_0000);
         wr(8'h0c, 32'h0000_0000);
         wcnt(s);
         wr(8'h10, 32'(p * 16 + 7));
         i_src.pulse(11);
         wr(8'h10, 32'h0000_0000);
         e = nxt(s, p, 11);
         chkcnt(e[15:0]);
         rc("flag", 8'h0c, 32'h0000_0001, 32'(e[16]));
      end
      done;
      wcnt(s);
      wr(8'h10, 32'h0000_000e);
      repeat (20) @(posedge clk);
      chk("osc drive", 32'(osc_out_pin), 32'h0000_0001);
      wr(8'h10, 32'h0000_000f);
      i_src.pulse(5);
      wr(8'h10, 32'h0000_0000);
      chkcnt(s + 16'h0005);
      done;
      wr(8'h8c, 32'h0000_0001);
      wr(8'h0b, 32'h0000_0040);
      wr(8'h0c, 32'h0000_0000);
      wcnt(16'hffff);
      sleep_active <= 1'h1;
      wr(8'h10, 32'h0000_0003);
      i_src.pulse(3);
      chkcnt(16'hffff);
      chk("wake", 32'(wake_q), 32'h0000_0000);
      wr(8'h10, 32'h0000_0007);
      i_src.pulse(1);
      chk("wake", 32'(wake_q), 32'h0000_0001);
      chk("vector", 32'(irq_vector_q), 32'h0000_0000);
      wr(8'h0b, 32'h0000_00c0);
      repeat (2) @(posedge clk);
      chk("vector", 32'(irq_vector_q), 32'h0000_0001);
      rc("enables", 8'h8c, 32'h0000_0001, 32'h0000_0001);
      wr(8'h0c, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk("wake", 32'(wake_q), 32'h0000_0000);
      sleep_active <= 1'h0;
      done;
      report_and_stop;
   end
endmodule // tb_acsw_counter
